// ### verilog/vpi_port.sv
// Pixel input port: capture, lane mapping, sync polarity, routing and rate selection.
// Functional notes
// R1: Three-bit mode field picks SD, ED/HD or ED at 54 MHz; SD after reset.
// R2: Narrow 8-bit DDR: luma and chroma share lanes 7..0 on opposite edges.
// R3: Two-bit edge field chooses the luma capture edge; 00 and 11 are valid.
// R4: ED at 54 MHz uses interleaved data and embedded codes only.
// R5: Wide 8-bit SD YCrCb: interleaved pixels on lanes 15..8.
// R6: 10-bit SD YCrCb: interleaved pixels on lanes 15..6.
// R7: 16-bit SD YCrCb: luma 15..8, chroma 7..0, every second clock.
// R8: SD RGB: red 4..0, green 10..5, blue 15..11.
// R9: Source supplies external sync in SD RGB mode.
// R10: Wide SD YCrCb takes embedded codes only at 8 and 10 bits.
// R11: ED/HD takes 16-bit SDR or 8/10-bit DDR data.
// R12: DDR and 54 MHz ED use lanes 15..8, or 15..6 with ten-bit enable.
// R13: SD outputs: G,B,R or Y,Pb,Pr or CVBS,luma,chroma with swap.
// R14: ED/HD outputs G,B,R or Y,Pb,Pr; swap exchanges second and third.
// R15: SD RGB output can reverse its colour order.
// R16: Oversampling PLL is off after reset; writing 0 enables it.
// R17: SD oversampling is 2x, or 8x/16x by rate bit with PLL on.
// R18: ED oversampling is 1x, or 4x/8x by rate bit with PLL on.
// R19: HD oversampling is 1x, or 2x/4x by HD rate bit with PLL on.
// R20: Sync is low in blanking unless compliance follows the format code.
// R21: ED/HD sync and blank inputs invert individually; SD sync cannot.
// R22: Edge value 00 takes luma on rising edges, 11 on falling edges.
// R23: Captured lanes are registered and paired into one luma/chroma word.
//
// Our own choices: the APB slave port and the address map.
`default_nettype none
module vpi_port (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    ce,
	input  wire logic [7:0]              paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    pixel_clock_input,
	input  wire logic [15:0]             pixel_bus,
	input  wire logic                    hd_line_sync_input,
	input  wire logic                    hd_frame_sync_input,
	input  wire logic                    hd_blank_input,
	input  wire logic                    sd_line_sync_input,
	input  wire logic                    sd_frame_sync_input,
	output logic                         pix_valid,
	output logic      [9:0]              pix_c0,
	output logic      [9:0]              pix_c1,
	output logic      [9:0]              pix_c2,
	output vpi_pkg::vpi_comp_t           dac_sel1,
	output vpi_pkg::vpi_comp_t           dac_sel2,
	output vpi_pkg::vpi_comp_t           dac_sel3,
	output vpi_pkg::vpi_os_t             os_rate,
	output logic                         pll_enable,
	output logic                         embedded_sync_en,
	output logic                         ext_sync_en,
	output logic                         line_blank,
	output logic                         frame_blank,
	output logic                         blank_active
);
	typedef struct packed {
		vpi_pkg::vpi_in_cfg_t   icfg;
		vpi_pkg::vpi_out_cfg_t  ocfg;
		vpi_pkg::vpi_sync_cfg_t scfg;
		logic [31:0]            prdata;
		logic                   pready;
		logic                   pslverr;
		logic                   clk_d;
		logic                   phase;
		logic [9:0]             held;
		vpi_pkg::vpi_pixel_t    pix;
		logic                   vld;
		vpi_pkg::vpi_comp_t     sel1;
		vpi_pkg::vpi_comp_t     sel2;
		vpi_pkg::vpi_comp_t     sel3;
		vpi_pkg::vpi_os_t       rate;
		logic                   pll_en;
		logic                   emb_en;
		logic                   ext_en;
		logic                   hs;
		logic                   vs;
		logic                   bl;
	} vpi_st_t;

	vpi_st_t                st;
	vpi_st_t                next_st;
	vpi_pkg::vpi_pins_t     raw;
	vpi_pkg::vpi_pins_t     syn;
	vpi_pkg::vpi_bus_t      bus;
	vpi_pkg::vpi_bus10_t    b10;
	vpi_pkg::vpi_rgb_t      rgb;
	logic                   is_ed54;
	logic                   is_edhd;
	logic                   is_sd;
	logic                   is_hd;
	logic                   rise;
	logic                   fall;
	logic                   luma_fall;
	logic                   act_hi;
	logic                   hit;
	logic [7:0]             byte_w;
	logic [9:0]             word;

	vpi_route_if rif ();

	assign raw = '{sd_v: sd_frame_sync_input, sd_h: sd_line_sync_input, hd_b: hd_blank_input,
		hd_v: hd_frame_sync_input, hd_h: hd_line_sync_input, bus: pixel_bus, clk: pixel_clock_input};

	vpi_sync3 #(
		.W($bits(vpi_pkg::vpi_pins_t))
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.d       (raw),
		.q       (syn)
	);

	assign rif.is_sd = is_sd;
	assign rif.ypbpr = st.ocfg.ypbpr_sel;
	assign rif.comp = st.ocfg.comp_sel;
	assign rif.lc_swap = st.ocfg.lc_swap;
	assign rif.col_swap = st.ocfg.col_swap;
	assign rif.rgb_rev = st.ocfg.rgb_rev;

	vpi_route u_route (
		.rif (rif.rt)
	);

	// Mode decode; unlisted codes behave as standard definition.
	assign is_ed54 = st.icfg.mode == vpi_pkg::MODE_ED54; // see R1
	assign is_edhd = st.icfg.mode == vpi_pkg::MODE_EDHD1 || st.icfg.mode == vpi_pkg::MODE_EDHD2;
	assign is_sd = !is_ed54 && !is_edhd;
	assign is_hd = is_edhd && st.ocfg.hd_sel;
	assign luma_fall = st.icfg.edge_sel == vpi_pkg::EDGE_FALL; // see R3, R22
	assign rise = syn.clk && !st.clk_d;
	assign fall = !syn.clk && st.clk_d;
	assign bus = syn.bus;
	assign b10 = syn.bus;
	assign rgb = syn.bus;
	assign byte_w = st.icfg.narrow ? bus.lo : bus.hi; // see R2, R5
	assign word = st.icfg.ten_bit ? b10.w10 : vpi_pkg::PIX_W'(byte_w); // see R12
	assign hit = paddr == vpi_pkg::ADDR_INPUT || paddr == vpi_pkg::ADDR_OUTPUT ||
		paddr == vpi_pkg::ADDR_SYNC || paddr == vpi_pkg::ADDR_STATUS || paddr == vpi_pkg::ADDR_PIXEL;
	assign act_hi = (is_sd ? st.scfg.cea_sd : st.scfg.cea_hd) && st.scfg.fmt[vpi_pkg::FMT_POL_BIT]; // see R20

	always_comb begin
		logic [31:0] rd;
		logic [9:0]  sdw;
		rd = '0;
		sdw = (st.icfg.width == vpi_pkg::WID_10) ? b10.w10 : vpi_pkg::PIX_W'(byte_w); // see R5, R6
		next_st = st;
		next_st.clk_d = syn.clk;
		next_st.vld = 1'b0;
		// Register bus: one wait state, then the answer.
		case (paddr)
			vpi_pkg::ADDR_INPUT: rd = st.icfg;
			vpi_pkg::ADDR_OUTPUT: rd = st.ocfg;
			vpi_pkg::ADDR_SYNC: rd = st.scfg;
			vpi_pkg::ADDR_STATUS: rd = vpi_pkg::vpi_status_t'{rsvd: '0, ext_ok: st.ext_en, emb_ok: st.emb_en,
				pll_on: st.pll_en, rate: st.rate};
			vpi_pkg::ADDR_PIXEL: rd = st.pix;
			default: rd = '0;
		endcase
		next_st.pready = psel && penable && !st.pready;
		next_st.pslverr = (psel && penable && !st.pready) ? !hit : 1'b0;
		if (psel && penable && !st.pready) begin
			next_st.prdata = rd;
		end
		if (psel && penable && st.pready && pwrite) begin
			case (paddr)
				vpi_pkg::ADDR_INPUT: next_st.icfg = pwdata & vpi_pkg::IN_MASK; // see R1, R3, R12
				vpi_pkg::ADDR_OUTPUT: next_st.ocfg = pwdata & vpi_pkg::OUT_MASK; // see R16
				vpi_pkg::ADDR_SYNC: next_st.scfg = pwdata & vpi_pkg::SYNC_MASK; // see R21
				default: next_st.pslverr = st.pslverr;
			endcase
		end
		// Capture and pairing.
		if (is_sd) begin
			if (st.icfg.rgb_in) begin
				if (rise) begin // see R8
					next_st.phase = !st.phase;
					if (st.phase) begin
						next_st.pix.c0 = vpi_pkg::PIX_W'(rgb.g);
						next_st.pix.c1 = vpi_pkg::PIX_W'(rgb.b);
						next_st.pix.c2 = vpi_pkg::PIX_W'(rgb.r);
						next_st.vld = 1'b1;
					end
				end
			end else if (st.icfg.width == vpi_pkg::WID_16) begin
				if (rise) begin // see R7
					next_st.phase = !st.phase;
					if (st.phase) begin
						next_st.pix.c0 = vpi_pkg::PIX_W'(bus.hi);
						next_st.pix.c1 = vpi_pkg::PIX_W'(bus.lo);
						next_st.pix.c2 = '0;
						next_st.vld = 1'b1;
					end
				end
			end else if (rise) begin // see R5, R6, R23
				next_st.phase = !st.phase;
				if (!st.phase) begin
					next_st.held = sdw;
				end else begin
					next_st.pix.c0 = sdw;
					next_st.pix.c1 = st.held;
					next_st.pix.c2 = '0;
					next_st.vld = 1'b1;
				end
			end
		end else if (is_ed54) begin
			if (rise) begin // see R4, R12
				next_st.phase = !st.phase;
				if (!st.phase) begin
					next_st.held = word;
				end else begin
					next_st.pix.c0 = word;
					next_st.pix.c1 = st.held;
					next_st.pix.c2 = '0;
					next_st.vld = 1'b1;
				end
			end
		end else if (st.icfg.width == vpi_pkg::WID_16) begin
			if (rise) begin // see R11
				next_st.pix.c0 = vpi_pkg::PIX_W'(bus.hi);
				next_st.pix.c1 = vpi_pkg::PIX_W'(bus.lo);
				next_st.pix.c2 = '0;
				next_st.vld = 1'b1;
			end
		end else begin
			if (luma_fall ? fall : rise) begin // see R2, R22
				next_st.held = word;
			end
			if (luma_fall ? rise : fall) begin // see R11, R23
				next_st.pix.c0 = st.held;
				next_st.pix.c1 = word;
				next_st.pix.c2 = '0;
				next_st.vld = 1'b1;
			end
		end
		// Sync levels, active high while in blanking.
		if (is_ed54) begin
			next_st.hs = 1'b0; // see R4
			next_st.vs = 1'b0;
			next_st.bl = 1'b0;
		end else if (is_sd) begin
			next_st.hs = syn.sd_h ^ !act_hi; // see R20, R21
			next_st.vs = syn.sd_v ^ !act_hi;
			next_st.bl = 1'b0;
		end else begin
			next_st.hs = syn.hd_h ^ st.scfg.inv_h ^ !act_hi; // see R21
			next_st.vs = syn.hd_v ^ st.scfg.inv_v ^ !act_hi;
			next_st.bl = syn.hd_b ^ st.scfg.inv_blank ^ !act_hi;
		end
		next_st.ext_en = !is_ed54; // see R4, R9
		next_st.emb_en = is_sd ? (!st.icfg.rgb_in && st.icfg.width != vpi_pkg::WID_16) : 1'b1; // see R10
		// Oversampling rate.
		next_st.pll_en = !st.ocfg.pll_off; // see R16
		if (st.ocfg.pll_off) begin
			next_st.rate = is_sd ? vpi_pkg::OS_2X : vpi_pkg::OS_1X; // see R17, R18, R19
		end else if (is_sd) begin
			next_st.rate = st.ocfg.sded_rate ? vpi_pkg::OS_8X : vpi_pkg::OS_16X; // see R17
		end else if (is_hd) begin
			next_st.rate = st.ocfg.hd_rate ? vpi_pkg::OS_2X : vpi_pkg::OS_4X; // see R19
		end else begin
			next_st.rate = st.ocfg.sded_rate ? vpi_pkg::OS_4X : vpi_pkg::OS_8X; // see R18
		end
		next_st.sel1 = rif.sel1; // see R13, R14
		next_st.sel2 = rif.sel2;
		next_st.sel3 = rif.sel3;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.icfg <= vpi_pkg::IN_RST; // see R1
			st.ocfg <= vpi_pkg::OUT_RST; // see R16
			st.scfg <= vpi_pkg::SYNC_RST;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign pix_valid = st.vld;
	assign pix_c0 = st.pix.c0;
	assign pix_c1 = st.pix.c1;
	assign pix_c2 = st.pix.c2;
	assign dac_sel1 = st.sel1;
	assign dac_sel2 = st.sel2;
	assign dac_sel3 = st.sel3;
	assign os_rate = st.rate;
	assign pll_enable = st.pll_en;
	assign embedded_sync_en = st.emb_en;
	assign ext_sync_en = st.ext_en;
	assign line_blank = st.hs;
	assign frame_blank = st.vs;
	assign blank_active = st.bl;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_pll_follow: assert property (ce && st.ocfg.pll_off |=> !pll_enable) // see R16
		else $error("PLL enabled while its control bit is one");
	chk_sd_rate: assert property (ce && is_sd && !st.ocfg.pll_off && !st.ocfg.sded_rate // see R17
		|=> os_rate == vpi_pkg::OS_16X)
		else $error("SD rate with PLL on is not 16x");
	chk_ed_rate: assert property (ce && is_ed54 && !st.ocfg.pll_off && st.ocfg.sded_rate // see R18
		|=> os_rate == vpi_pkg::OS_4X)
		else $error("ED rate with PLL on is not 4x");
	chk_hd_rate: assert property (ce && is_hd && !st.ocfg.pll_off && st.ocfg.hd_rate // see R19
		|=> os_rate == vpi_pkg::OS_2X)
		else $error("HD rate with PLL on is not 2x");
	chk_ed54_nosync: assert property (ce && is_ed54 |=> !ext_sync_en && embedded_sync_en && !line_blank) // see R4
		else $error("External sync used at 54 MHz");
	chk_sd_embed: assert property (ce && is_sd && st.icfg.width == vpi_pkg::WID_16 |=> !embedded_sync_en) // see R10
		else $error("Embedded codes accepted at 16 bits");
	chk_ddr_pair: assert property (ce && is_edhd && st.icfg.width == vpi_pkg::WID_8 && !luma_fall && fall
		|=> pix_valid && pix_c0 == $past(st.held)) // see R22
		else $error("DDR pair not emitted on chroma edge");
	chk_sdr_word: assert property (ce && is_edhd && st.icfg.width == vpi_pkg::WID_16 && rise
		|=> pix_valid && pix_c0 == vpi_pkg::PIX_W'($past(bus.hi))) // see R11
		else $error("16-bit luma lane mismatch");
	chk_route_sd: assert property (ce && is_sd && st.ocfg.ypbpr_sel && st.ocfg.comp_sel && st.ocfg.lc_swap
		|=> dac_sel1 == vpi_pkg::C_CVBS && dac_sel2 == vpi_pkg::C_CHROMA) // see R13
		else $error("SD composite routing wrong");
	chk_hd_invert: assert property (ce && is_edhd && !act_hi && st.scfg.inv_h // see R21
		|=> line_blank == $past(syn.hd_h))
		else $error("Line sync inversion wrong");
	chk_apb_wait: assert property (ce && psel && penable && !pready |=> pready)
		else $error("APB answer missing");
	chk_apb_err: assert property (ce && psel && penable && !pready && !hit |=> pready && pslverr)
		else $error("Unmapped access without error response");
	chk_sd_noinv: assert property (ce && is_sd && !act_hi && st.scfg.inv_h // see R21
		|=> line_blank == !$past(syn.sd_h))
		else $error("SD line sync was inverted");
	chk_ed54_pair: assert property (ce && is_ed54 && rise && st.phase // see R4, R23
		|=> pix_valid && pix_c1 == $past(st.held))
		else $error("ED 54 MHz pair not emitted on luma edge");

	cov_ddr_pixel: cover property (is_edhd && st.icfg.width == vpi_pkg::WID_8 && pix_valid);
	cov_rgb_pixel: cover property (is_sd && st.icfg.rgb_in && pix_valid);
	cov_ed54_pixel: cover property (is_ed54 && pix_valid);
	cov_sd10_pixel: cover property (is_sd && st.icfg.width == vpi_pkg::WID_10 && pix_valid);
	cov_apb_write: cover property (psel && penable && pready && pwrite);
endmodule
`default_nettype wire

// ### include/vpi_pkg.sv
// Package with register layouts, codes and constants of the video pixel input port.
`default_nettype none
package vpi_pkg;
	localparam int PIX_W = 10;
	localparam int FMT_POL_BIT = 0;

	localparam logic [7:0] ADDR_INPUT  = 8'h00;
	localparam logic [7:0] ADDR_OUTPUT = 8'h04;
	localparam logic [7:0] ADDR_SYNC   = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_PIXEL  = 8'h10;

	localparam logic [31:0] IN_MASK   = 32'h00000f77;
	localparam logic [31:0] OUT_MASK  = 32'h000001ff;
	localparam logic [31:0] SYNC_MASK = 32'h000007fb;
	localparam logic [31:0] IN_RST    = 32'h00000000;
	localparam logic [31:0] OUT_RST   = 32'h00000020;
	localparam logic [31:0] SYNC_RST  = 32'h00000000;

	localparam logic [2:0] MODE_SD    = 3'h0;
	localparam logic [2:0] MODE_EDHD1 = 3'h1;
	localparam logic [2:0] MODE_EDHD2 = 3'h2;
	localparam logic [2:0] MODE_ED54  = 3'h7;
	localparam logic [1:0] WID_8      = 2'h0;
	localparam logic [1:0] WID_16     = 2'h1;
	localparam logic [1:0] WID_10     = 2'h2;
	localparam logic [1:0] EDGE_FALL  = 2'h3;

	typedef struct packed {
		logic [19:0] rsvd1;
		logic        narrow;
		logic        ten_bit;
		logic [1:0]  width;
		logic        rsvd0;
		logic [2:0]  mode;
		logic        rsvd;
		logic [1:0]  edge_sel;
		logic        rgb_in;
	} vpi_in_cfg_t;

	typedef struct packed {
		logic [22:0] rsvd;
		logic        hd_sel;
		logic        hd_rate;
		logic        sded_rate;
		logic        pll_off;
		logic        rgb_rev;
		logic        col_swap;
		logic        lc_swap;
		logic        comp_sel;
		logic        ypbpr_sel;
	} vpi_out_cfg_t;

	typedef struct packed {
		logic [20:0] rsvd;
		logic        inv_blank;
		logic        inv_v;
		logic        inv_h;
		logic [4:0]  fmt;
		logic        rsvd0;
		logic        cea_sd;
		logic        cea_hd;
	} vpi_sync_cfg_t;

	typedef enum logic [2:0] {
		OS_1X  = 3'b000,
		OS_2X  = 3'b001,
		OS_4X  = 3'b010,
		OS_8X  = 3'b011,
		OS_16X = 3'b100
	} vpi_os_t;

	typedef enum logic [3:0] {
		C_G      = 4'b0000,
		C_B      = 4'b0001,
		C_R      = 4'b0010,
		C_Y      = 4'b0011,
		C_PB     = 4'b0100,
		C_PR     = 4'b0101,
		C_CVBS   = 4'b0110,
		C_LUMA   = 4'b0111,
		C_CHROMA = 4'b1000
	} vpi_comp_t;

	typedef struct packed {
		logic [25:0] rsvd;
		logic        ext_ok;
		logic        emb_ok;
		logic        pll_on;
		vpi_os_t     rate;
	} vpi_status_t;

	typedef struct packed {
		logic [1:0]       rsvd;
		logic [PIX_W-1:0] c2;
		logic [PIX_W-1:0] c1;
		logic [PIX_W-1:0] c0;
	} vpi_pixel_t;

	typedef struct packed {
		logic        sd_v;
		logic        sd_h;
		logic        hd_b;
		logic        hd_v;
		logic        hd_h;
		logic [15:0] bus;
		logic        clk;
	} vpi_pins_t;

	typedef struct packed { logic [7:0] hi; logic [7:0] lo; } vpi_bus_t;
	typedef struct packed { logic [9:0] w10; logic [5:0] low; } vpi_bus10_t;
	typedef struct packed { logic [4:0] b; logic [5:0] g; logic [4:0] r; } vpi_rgb_t;
endpackage
`default_nettype wire

// ### include/vpi_route_if.sv
// Interface between the pixel port core and its output routing logic.
`default_nettype none
interface vpi_route_if;
	logic                is_sd;
	logic                ypbpr;
	logic                comp;
	logic                lc_swap;
	logic                col_swap;
	logic                rgb_rev;
	vpi_pkg::vpi_comp_t  sel1;
	vpi_pkg::vpi_comp_t  sel2;
	vpi_pkg::vpi_comp_t  sel3;
	modport ctl (output is_sd, ypbpr, comp, lc_swap, col_swap, rgb_rev, input sel1, sel2, sel3);
	modport rt (input is_sd, ypbpr, comp, lc_swap, col_swap, rgb_rev, output sel1, sel2, sel3);
endinterface
`default_nettype wire

// ### verilog/vpi_sync3.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`default_nettype none
module vpi_sync3 #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} vpi_sync_st_t;

	vpi_sync_st_t st;
	vpi_sync_st_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = d;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.q[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign q = st.q;
endmodule
`default_nettype wire

// ### verilog/vpi_route.sv
// Selection of the component carried by each of the three outputs.
`default_nettype none
module vpi_route (
	vpi_route_if.rt rif
);
	always_comb begin
		rif.sel1 = vpi_pkg::C_G;
		rif.sel2 = vpi_pkg::C_B;
		rif.sel3 = vpi_pkg::C_R;
		if (rif.is_sd) begin
			if (!rif.ypbpr) begin
				if (rif.rgb_rev) begin // see R15
					rif.sel2 = vpi_pkg::C_R;
					rif.sel3 = vpi_pkg::C_B;
				end
			end else if (!rif.comp) begin // see R13
				rif.sel1 = vpi_pkg::C_Y;
				rif.sel2 = vpi_pkg::C_PB;
				rif.sel3 = vpi_pkg::C_PR;
			end else begin
				rif.sel1 = vpi_pkg::C_CVBS;
				rif.sel2 = rif.lc_swap ? vpi_pkg::C_CHROMA : vpi_pkg::C_LUMA; // see R13
				rif.sel3 = rif.lc_swap ? vpi_pkg::C_LUMA : vpi_pkg::C_CHROMA;
			end
		end else begin
			if (rif.ypbpr) begin // see R14
				rif.sel1 = vpi_pkg::C_Y;
				rif.sel2 = rif.col_swap ? vpi_pkg::C_PR : vpi_pkg::C_PB;
				rif.sel3 = rif.col_swap ? vpi_pkg::C_PB : vpi_pkg::C_PR;
			end else begin
				rif.sel2 = rif.col_swap ? vpi_pkg::C_R : vpi_pkg::C_B; // see R14
				rif.sel3 = rif.col_swap ? vpi_pkg::C_B : vpi_pkg::C_R;
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench/vpi_src.sv
// Behavioural video source that drives the pixel clock and pixel lanes.
`default_nettype none
module vpi_src (
	input  wire logic        pclk,
	output logic             clk,
	output logic      [15:0] bus
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		clk = 1'b0;
		bus = 16'h0000;
	end
	// Data settles before the clock edge and holds well past it, then the lanes go to a changed value.
	task automatic drive(input logic lvl, input logic [15:0] d);
		@(posedge pclk);
		bus <= d;
		repeat (2) @(posedge pclk);
		clk <= lvl;
		repeat (6) @(posedge pclk);
		bus <= ~d;
	endtask
endmodule
`default_nettype wire

// ### testbench/video_pixel_input_port_tb.sv
// Self-checking testbench of the video pixel input port.
`default_nettype none
module video_pixel_input_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        hl = 1'b1;
	logic        hf = 1'b1;
	logic        hb = 1'b1;
	logic        sl = 1'b1;
	logic        sf = 1'b1;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pv;
	logic [9:0]  c0, c1, c2, g0, g1, g2;
	vpi_pkg::vpi_comp_t s1, s2, s3;
	vpi_pkg::vpi_os_t   osr;
	logic        plle, emb, ext, lb, fb, ba, sclk;
	logic [15:0] sbus;
	logic [31:0] rq;
	logic        re;
	int          fails = 0;
	int          tests_run = 0;
	int          cyc = 0;
	always #12.5 pclk = ~pclk;
	vpi_src i_src (.pclk(pclk), .clk(sclk), .bus(sbus));
	vpi_port i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pixel_clock_input(sclk), .pixel_bus(sbus), .hd_line_sync_input(hl),
		.hd_frame_sync_input(hf), .hd_blank_input(hb), .sd_line_sync_input(sl),
		.sd_frame_sync_input(sf), .pix_valid(pv), .pix_c0(c0), .pix_c1(c1), .pix_c2(c2),
		.dac_sel1(s1), .dac_sel2(s2), .dac_sel3(s3), .os_rate(osr), .pll_enable(plle),
		.embedded_sync_en(emb), .ext_sync_en(ext), .line_blank(lb), .frame_blank(fb),
		.blank_active(ba));
	always @(posedge pclk) begin
		if (pv === 1'b1) begin
			g0 <= c0;
			g1 <= c1;
			g2 <= c2;
		end
	end
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			summarize;
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_reset;
		repeat (2) @(posedge pclk);
		chk("os_rate", 32'(vpi_pkg::OS_2X), 32'(osr));
		chk("pll_enable", 32'h0, 32'(plle));
		chk("dac_sel", 32'h012, {20'h0, s1, s2, s3});
		apb(1'b0, vpi_pkg::ADDR_INPUT, 32'h0);
		chk("input reg", vpi_pkg::IN_RST, rq);
		apb(1'b0, vpi_pkg::ADDR_OUTPUT, 32'h0);
		chk("output reg", vpi_pkg::OUT_RST, rq);
		apb(1'b1, vpi_pkg::ADDR_INPUT, 32'hffffffff);
		apb(1'b0, vpi_pkg::ADDR_INPUT, 32'h0);
		chk("input mask", vpi_pkg::IN_MASK, rq);
		apb(1'b1, 8'h14, 32'hffffffff);
		chk("unmapped err", 32'h1, 32'(re));
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped read", 32'h0, rq);
	endtask
	task automatic t_rate(input logic [2:0] m, input logic [31:0] o, input vpi_pkg::vpi_os_t e);
		apb(1'b1, vpi_pkg::ADDR_INPUT, 32'(m) << 4);
		apb(1'b1, vpi_pkg::ADDR_OUTPUT, o);
		repeat (3) @(posedge pclk);
		chk("os_rate", 32'(e), 32'(osr));
		chk("pll_enable", 32'(!o[5]), 32'(plle));
	endtask
	task automatic t_rt(input logic [2:0] m, input logic [31:0] o, input logic [11:0] e);
		apb(1'b1, vpi_pkg::ADDR_INPUT, 32'(m) << 4);
		apb(1'b1, vpi_pkg::ADDR_OUTPUT, o);
		repeat (3) @(posedge pclk);
		chk("dac_sel", 32'(e), {20'h0, s1, s2, s3});
	endtask
	task automatic t_sy(input logic [2:0] m, input logic [31:0] s, input logic h, input logic [2:0] e);
		apb(1'b1, vpi_pkg::ADDR_INPUT, 32'(m) << 4);
		apb(1'b1, vpi_pkg::ADDR_SYNC, s);
		hl <= h;
		hf <= h;
		hb <= h;
		sl <= h;
		sf <= h;
		repeat (8) @(posedge pclk);
		chk("sync levels", 32'(e), {29'h0, lb, fb, ba});
	endtask
	task automatic t_en(input logic [31:0] i, input logic [1:0] e);
		apb(1'b1, vpi_pkg::ADDR_INPUT, i);
		repeat (3) @(posedge pclk);
		chk("sync_en", 32'(e), {30'h0, emb, ext});
	endtask
	task automatic t_ddr(input logic [1:0] e, input logic nar);
		int sh;
		sh = nar ? 0 : 8;
		apb(1'b1, vpi_pkg::ADDR_INPUT, (32'(nar) << 11) | 32'h20 | (32'(e) << 1));
		if (e == vpi_pkg::EDGE_FALL) begin
			i_src.drive(1'b1, 16'h0000);
		end
		i_src.drive(e != vpi_pkg::EDGE_FALL, 16'(16'h5a << sh));
		i_src.drive(e == vpi_pkg::EDGE_FALL, 16'(16'hc3 << sh));
		repeat (10) @(posedge pclk);
		chk("ddr luma", 32'h5a, 32'(g0));
		chk("ddr chroma", 32'hc3, 32'(g1));
	endtask
	task automatic t_sd2(input logic [31:0] i, input logic [15:0] d, input logic [29:0] e);
		apb(1'b1, vpi_pkg::ADDR_INPUT, i);
		repeat (3) begin
			i_src.drive(1'b1, d);
			i_src.drive(1'b0, d);
		end
		repeat (10) @(posedge pclk);
		chk("sd pixel", 32'(e), {2'h0, g2, g1, g0});
		apb(1'b0, vpi_pkg::ADDR_PIXEL, 32'h0);
		chk("pixel reg", 32'(e), rq);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_rate(3'h0, 32'h20, vpi_pkg::OS_2X);
		t_rate(3'h0, 32'h40, vpi_pkg::OS_8X);
		t_rate(3'h0, 32'h00, vpi_pkg::OS_16X);
		t_rate(3'h1, 32'h20, vpi_pkg::OS_1X);
		t_rate(3'h2, 32'h40, vpi_pkg::OS_4X);
		t_rate(3'h1, 32'h00, vpi_pkg::OS_8X);
		t_rate(3'h7, 32'h40, vpi_pkg::OS_4X);
		t_rate(3'h1, 32'h120, vpi_pkg::OS_1X);
		t_rate(3'h1, 32'h180, vpi_pkg::OS_2X);
		t_rate(3'h2, 32'h100, vpi_pkg::OS_4X);
		t_rt(3'h0, 32'h00, 12'h012);
		t_rt(3'h0, 32'h01, 12'h345);
		t_rt(3'h0, 32'h03, 12'h678);
		t_rt(3'h0, 32'h07, 12'h687);
		t_rt(3'h0, 32'h10, 12'h021);
		t_rt(3'h2, 32'h08, 12'h021);
		t_rt(3'h7, 32'h09, 12'h354);
		t_sy(3'h1, 32'h0, 1'b0, 3'h7);
		t_sy(3'h1, 32'h0, 1'b1, 3'h0);
		t_sy(3'h1, 32'h100, 1'b1, 3'h4);
		t_sy(3'h0, 32'h100, 1'b0, 3'h6);
		t_sy(3'h0, 32'h0a, 1'b1, 3'h6);
		t_sy(3'h2, 32'h09, 1'b1, 3'h7);
		t_en(32'h70, 2'b10);
		t_en(32'h01, 2'b01);
		t_en(32'h100, 2'b01);
		t_en(32'h00, 2'b11);
		t_ddr(2'h0, 1'b0);
		t_ddr(2'h0, 1'b1);
		t_ddr(vpi_pkg::EDGE_FALL, 1'b0);
		t_sd2(32'h1, {5'h0b, 6'h2a, 5'h15}, {10'h15, 10'h0b, 10'h2a});
		t_sd2(32'h100, 16'h8040, {10'h0, 10'h40, 10'h80});
		t_sd2(32'h110, 16'h2191, {10'h0, 10'h91, 10'h21});
		t_sd2(32'h70, 16'h5a00, {10'h0, 10'h5a, 10'h5a});
		t_sd2(32'h470, 16'hd6c0, {10'h0, 10'h35b, 10'h35b});
		t_sd2(32'h200, 16'h1280, {10'h0, 10'h4a, 10'h4a});
		t_sd2(32'h000, 16'he700, {10'h0, 10'he7, 10'he7});
		summarize;
	end
endmodule
`default_nettype wire
